// *** core/uart_channel_core.v ***
/*
  One asynchronous serial channel: holding and shift registers for both
  directions, line format control, prioritised interrupt status and modem
  control with loop-back. Assumes clk_sys_in is the only clock, all inputs
  are synchronous to it, and the host strobes are single-cycle.
*/
// Chosen here: the register addresses and the strobed register port.
`timescale 1ns/100ps
`default_nettype none
`include "uart_channel_consts.vh"

// Overview of operation
// - Host write loads 8-bit data into tx holding register when it may accept.
// - Holding-empty flag sets only when the character moves to the shifter.
// - Start edge counted at 16x; sampled after 7.5 clocks, high means false start.
// - Enable bit 0 gates receive-ready, raised while rx holding register full.
// - Enable bit 1 gates transmit-empty, raised when tx holding register empties.
// - Enable bit 2 gates line status interrupt; resets to zero.
// - Enable bit 3 gates modem status interrupt; upper enable bits read zero.
// - Status reports highest pending level: 0110, 0100, 0010, 0000.
// - Reading status clears only a reported transmit-empty interrupt; lower ones follow.
// - Status bit 0 low when pending, high when idle; bits 7:4 zero.
// - Line control bits 1:0 pick five to eight data bits.
// - Bit 2 gives one stop bit, or 1.5 with five bits, else 2.
// - Bit 3 adds parity on transmit and checks it on receive.
// - Bit 4 picks odd when zero, even when one.
// - With bit 5 set parity is fixed to not bit 4.
// - Outside loop-back, bit 6 holds serial output low for break until cleared.
// - Bit 7 redirects offsets zero and one to the divisor latch.
// - Outside loop-back, modem bits 0 and 1 drive terminal-ready and request-to-send pins inverted.
// - Modem bit 2 supplies ring indicate only in loop-back.
// - Modem bit 3 enables interrupt pin drive; in loop-back drives carrier detect.
// - Modem bit 4 enables loop-back; bits 7:5 read zero.
// - In loop-back clear-to-send status mirrors request-to-send control bit.
// - Divisor registers reachable only with chip select and bit 7 set.
module uart_channel_core (
  input wire clk_sys_in,
  input wire sys_rst_in,
  input wire cs_in,
  input wire [2:0] addr_in,
  input wire [7:0] wdata_in,
  input wire wr_in,
  input wire rd_in,
  output reg [7:0] rdata_out,
  input wire rx_in,
  output wire tx_out,
  input wire cts_n_in,
  input wire dsr_n_in,
  input wire ring_indicate_n_in,
  input wire carrier_detect_n_in,
  output wire dtr_n_out,
  output wire rts_n_out,
  output wire irq_out,
  output wire irq_oe_n_out
);

  localparam TX_IDLE = 3'h0;
  localparam TX_START = 3'h1;
  localparam TX_DATA = 3'h2;
  localparam TX_PAR = 3'h3;
  localparam TX_STOP = 3'h4;
  localparam RX_IDLE = 3'h0;
  localparam RX_START = 3'h1;
  localparam RX_DATA = 3'h2;
  localparam RX_PAR = 3'h3;
  localparam RX_STOP = 3'h4;

  reg [7:0] line_control_r;
  reg [3:0] irq_enable_r;
  reg [4:0] modem_control_r;
  reg [15:0] divisor_r;
  reg [7:0] scratch_r;
  reg [7:0] tx_holding_r;
  reg tx_holding_full_r;
  reg [7:0] tx_shifter_r;
  reg [2:0] tx_state_r;
  reg [3:0] tx_tick_r;
  reg [2:0] tx_bit_r;
  reg [1:0] tx_stop_r;
  reg tx_line_r;
  reg tx_par_r;
  reg [7:0] rx_holding_r;
  reg rx_ready_r;
  reg [7:0] rx_shifter_r;
  reg [2:0] rx_state_r;
  reg [3:0] rx_tick_r;
  reg [2:0] rx_bit_r;
  reg rx_par_r;
  reg rx_prev_r;
  reg overrun_r;
  reg parity_err_r;
  reg framing_err_r;
  reg break_r;
  reg tx_irq_r;
  reg [3:0] msr_delta_r;
  reg [3:0] msr_prev_r;
  reg [15:0] baud_cnt_r;
  reg tick_r;

  // Character length field to index of last data bit
  function [2:0] last_bit;
    input [1:0] len;
    begin
      last_bit = {1'b1, len};
    end
  endfunction

  // Parity bit for a character: forced, odd or even
  function par_bit;
    input [7:0] lc;
    input [7:0] data;
    reg [7:0] masked;
    begin
      masked = data & ~(8'hff << ({3'h0, lc[1:0]} + 4'h5));
      if (lc[`LC_FORCE])
        par_bit = ~lc[`LC_EVEN];
      else
        par_bit = (^masked) ^ ~lc[`LC_EVEN];
    end
  endfunction

  wire loop_w = modem_control_r[`MC_LOOP];
  wire dlab_w = line_control_r[`LC_DLAB];
  wire wr_w = cs_in & wr_in;
  wire rd_w = cs_in & rd_in;
  wire div_sel_w = dlab_w & ~addr_in[2] & ~addr_in[1];
  wire rx_line_w = loop_w ? tx_line_r : rx_in;
  // Loop-back modem lines feed status from control bits
  wire cts_w = loop_w ? modem_control_r[`MC_RTS] : ~cts_n_in;
  wire dsr_w = loop_w ? modem_control_r[`MC_DTR] : ~dsr_n_in;
  wire ri_w = loop_w ? modem_control_r[`MC_OUT1] : ~ring_indicate_n_in;
  wire cd_w = loop_w ? modem_control_r[`MC_OUT2] : ~carrier_detect_n_in;
  wire [3:0] msr_now_w = {cd_w, ri_w, dsr_w, cts_w};
  wire line_pend_w = irq_enable_r[`IE_LINE] &
    (overrun_r | parity_err_r | framing_err_r | break_r);
  wire rx_pend_w = irq_enable_r[`IE_RX] & rx_ready_r;
  wire tx_pend_w = irq_enable_r[`IE_TX] & tx_irq_r;
  wire modem_pend_w = irq_enable_r[`IE_MODEM] & (|msr_delta_r);
  reg [3:0] isr_w;

  always @*
  begin
    if (line_pend_w)
      isr_w = `ISR_LINE;
    else if (rx_pend_w)
      isr_w = `ISR_RX;
    else if (tx_pend_w)
      isr_w = `ISR_TX;
    else if (modem_pend_w)
      isr_w = `ISR_MODEM;
    else
      isr_w = `ISR_NONE;
  end

  wire tx_empty_w = ~tx_holding_full_r;
  wire tsr_empty_w = tx_empty_w & (tx_state_r == TX_IDLE);
  wire [7:0] line_status_w = {1'b0, tsr_empty_w, tx_empty_w, break_r,
    framing_err_r, parity_err_r, overrun_r, rx_ready_r};
  wire [7:0] modem_status_w = {msr_now_w, msr_delta_r};

  // Line driving: break overrides, loop-back keeps pin idle
  assign tx_out = loop_w ? 1'b1 : (tx_line_r & ~line_control_r[`LC_BREAK]);
  assign dtr_n_out = loop_w | ~modem_control_r[`MC_DTR];
  assign rts_n_out = loop_w | ~modem_control_r[`MC_RTS];
  assign irq_out = ~isr_w[0];
  assign irq_oe_n_out = ~modem_control_r[`MC_OUT2];

  // 16x rate enable from the divisor; zero divisor treated as one
  always @(posedge clk_sys_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      baud_cnt_r <= 16'h0000;
      tick_r <= 1'b0;
    end
    else if (baud_cnt_r + 16'h0001 >= divisor_r)
    begin
      baud_cnt_r <= 16'h0000;
      tick_r <= 1'b1;
    end
    else
    begin
      baud_cnt_r <= baud_cnt_r + 16'h0001;
      tick_r <= 1'b0;
    end
  end

  // Register writes and read data
  always @(posedge clk_sys_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      line_control_r <= `LINE_CONTROL_RESET;
      irq_enable_r <= `IRQ_ENABLE_RESET;
      modem_control_r <= `MODEM_CONTROL_RESET;
      divisor_r <= `DIVISOR_RESET;
      scratch_r <= `SCRATCH_RESET;
      rdata_out <= 8'h00;
    end
    else
    begin
      if (wr_w)
      begin
        case (addr_in)
          `ADDR_DATA: if (div_sel_w) divisor_r[7:0] <= wdata_in;
          `ADDR_IRQ_ENABLE:
            if (dlab_w) divisor_r[15:8] <= wdata_in;
            else irq_enable_r <= wdata_in[3:0];
          `ADDR_LINE_CONTROL: line_control_r <= wdata_in;
          `ADDR_MODEM_CONTROL: modem_control_r <= wdata_in[4:0];
          `ADDR_SCRATCH: scratch_r <= wdata_in;
          default: scratch_r <= scratch_r;
        endcase
      end
      rdata_out <= 8'h00;
      if (rd_w)
      begin
        case (addr_in)
          `ADDR_DATA: rdata_out <= dlab_w ? divisor_r[7:0] : rx_holding_r;
          `ADDR_IRQ_ENABLE: rdata_out <= dlab_w ? divisor_r[15:8] : {4'h0, irq_enable_r};
          `ADDR_IRQ_STATUS: rdata_out <= {4'h0, isr_w};
          `ADDR_LINE_CONTROL: rdata_out <= line_control_r;
          `ADDR_MODEM_CONTROL: rdata_out <= {3'h0, modem_control_r};
          `ADDR_LINE_STATUS: rdata_out <= line_status_w;
          `ADDR_MODEM_STATUS: rdata_out <= modem_status_w;
          default: rdata_out <= scratch_r;
        endcase
      end
    end
  end

  wire thr_wr_w = wr_w & (addr_in == `ADDR_DATA) & ~dlab_w;
  wire isr_rd_w = rd_w & (addr_in == `ADDR_IRQ_STATUS);
  wire lsr_rd_w = rd_w & (addr_in == `ADDR_LINE_STATUS);
  wire msr_rd_w = rd_w & (addr_in == `ADDR_MODEM_STATUS);
  wire rhr_rd_w = rd_w & (addr_in == `ADDR_DATA) & ~dlab_w;
  wire tx_load_w = tick_r & (tx_state_r == TX_IDLE) & tx_holding_full_r;
  wire tx_bit_end_w = tick_r & (tx_tick_r == `OVERSAMPLE);

  // Transmitter
  always @(posedge clk_sys_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      tx_holding_r <= 8'h00;
      tx_holding_full_r <= 1'b0;
      tx_irq_r <= 1'b1;
      tx_shifter_r <= 8'h00;
      tx_state_r <= TX_IDLE;
      tx_tick_r <= 4'h0;
      tx_bit_r <= 3'h0;
      tx_stop_r <= 2'h0;
      tx_line_r <= 1'b1;
      tx_par_r <= 1'b0;
    end
    else
    begin
      // Writes while both stages are busy are dropped
      if (thr_wr_w & (tx_empty_w | tx_load_w))
      begin
        tx_holding_r <= wdata_in;
        tx_holding_full_r <= 1'b1;
      end
      else if (tx_load_w)
        tx_holding_full_r <= 1'b0;
      // Character move sets the event over a same-cycle status read
      if (tx_load_w & ~thr_wr_w)
        tx_irq_r <= 1'b1;
      else if (thr_wr_w | (isr_rd_w & isr_w == `ISR_TX))
        tx_irq_r <= 1'b0;
      if (tick_r)
        tx_tick_r <= (tx_state_r == TX_IDLE) ? 4'h0 : tx_tick_r + 4'h1;
      case (tx_state_r)
        TX_IDLE:
          if (tx_load_w)
          begin
            tx_shifter_r <= tx_holding_r;
            tx_par_r <= par_bit(line_control_r, tx_holding_r);
            tx_line_r <= 1'b0;
            tx_state_r <= TX_START;
          end
        TX_START:
          if (tx_bit_end_w)
          begin
            tx_line_r <= tx_shifter_r[0];
            tx_bit_r <= 3'h0;
            tx_state_r <= TX_DATA;
          end
        TX_DATA:
          if (tx_bit_end_w)
          begin
            if (tx_bit_r == last_bit(line_control_r[1:0]))
            begin
              if (line_control_r[`LC_PAR_EN])
              begin
                tx_line_r <= tx_par_r;
                tx_state_r <= TX_PAR;
              end
              else
              begin
                tx_line_r <= 1'b1;
                tx_stop_r <= 2'h0;
                tx_state_r <= TX_STOP;
              end
            end
            else
            begin
              tx_shifter_r <= {1'b0, tx_shifter_r[7:1]};
              tx_line_r <= tx_shifter_r[1];
              tx_bit_r <= tx_bit_r + 3'h1;
            end
          end
        TX_PAR:
          if (tx_bit_end_w)
          begin
            tx_line_r <= 1'b1;
            tx_stop_r <= 2'h0;
            tx_state_r <= TX_STOP;
          end
        TX_STOP:
          // Half-bit steps: 2 for one stop, 3 for 1.5, 4 for two
          if (tick_r & (tx_tick_r[2:0] == `HALF_BIT))
          begin
            tx_stop_r <= tx_stop_r + 2'h1;
            if ((~line_control_r[`LC_STOP] & tx_stop_r == 2'h1) |
                (line_control_r[`LC_STOP] & line_control_r[1:0] == 2'h0 & tx_stop_r == 2'h2) |
                (tx_stop_r == 2'h3))
              tx_state_r <= TX_IDLE;
          end
        default: tx_state_r <= TX_IDLE;
      endcase
    end
  end

  wire rx_mid_w = tick_r & (rx_tick_r == `OVERSAMPLE);

  // Receiver
  always @(posedge clk_sys_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      rx_holding_r <= 8'h00;
      rx_ready_r <= 1'b0;
      rx_shifter_r <= 8'h00;
      rx_state_r <= RX_IDLE;
      rx_tick_r <= 4'h0;
      rx_bit_r <= 3'h0;
      rx_par_r <= 1'b0;
      rx_prev_r <= 1'b1;
      overrun_r <= 1'b0;
      parity_err_r <= 1'b0;
      framing_err_r <= 1'b0;
      break_r <= 1'b0;
    end
    else
    begin
      rx_prev_r <= rx_line_w;
      if (rhr_rd_w)
        rx_ready_r <= 1'b0;
      // Errors clear on a status read unless raised in the same cycle
      if (lsr_rd_w)
      begin
        overrun_r <= 1'b0;
        parity_err_r <= 1'b0;
        framing_err_r <= 1'b0;
        break_r <= 1'b0;
      end
      if (tick_r)
        rx_tick_r <= rx_tick_r + 4'h1;
      case (rx_state_r)
        RX_IDLE:
          if (rx_prev_r & ~rx_line_w)
          begin
            rx_tick_r <= 4'h0;
            rx_state_r <= RX_START;
          end
        RX_START:
          // Falling edge lands mid-tick, so seven ticks is the 7.5 point
          if (tick_r & (rx_tick_r == `START_SAMPLE - 4'h1))
          begin
            rx_tick_r <= 4'h0;
            rx_bit_r <= 3'h0;
            rx_shifter_r <= 8'h00;
            rx_state_r <= rx_line_w ? RX_IDLE : RX_DATA;
          end
        RX_DATA:
          if (rx_mid_w)
          begin
            rx_shifter_r[rx_bit_r] <= rx_line_w;
            rx_bit_r <= rx_bit_r + 3'h1;
            if (rx_bit_r == last_bit(line_control_r[1:0]))
              rx_state_r <= line_control_r[`LC_PAR_EN] ? RX_PAR : RX_STOP;
          end
        RX_PAR:
          if (rx_mid_w)
          begin
            rx_par_r <= rx_line_w;
            rx_state_r <= RX_STOP;
          end
        RX_STOP:
          // Only the first stop bit is checked
          if (rx_mid_w)
          begin
            rx_state_r <= RX_IDLE;
            if (line_control_r[`LC_PAR_EN] & (rx_par_r != par_bit(line_control_r, rx_shifter_r)))
              parity_err_r <= 1'b1;
            if (~rx_line_w)
              framing_err_r <= 1'b1;
            if (~rx_line_w & ~(|rx_shifter_r))
              break_r <= 1'b1;
            if (rx_ready_r & ~rhr_rd_w)
              overrun_r <= 1'b1;
            else
            begin
              rx_holding_r <= rx_shifter_r;
              rx_ready_r <= 1'b1;
            end
          end
        default: rx_state_r <= RX_IDLE;
      endcase
    end
  end

  // Modem change flags: a change beats a same-cycle read
  always @(posedge clk_sys_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      msr_prev_r <= 4'h0;
      msr_delta_r <= 4'h0;
    end
    else
    begin
      msr_prev_r <= msr_now_w;
      msr_delta_r <= (msr_rd_w ? 4'h0 : msr_delta_r) |
        {msr_prev_r[3] ^ cd_w, msr_prev_r[2] & ~ri_w,
        msr_prev_r[1] ^ dsr_w, msr_prev_r[0] ^ cts_w};
    end
  end

endmodule
`default_nettype wire

// *** core/uart_channel_consts.vh ***
/*
  Constants for the serial channel core: register addresses, field
  positions, reset values and timing counts.
  Assumes inclusion by bare name from the channel core only.
*/
`ifndef UART_CHANNEL_CONSTS_VH
`define UART_CHANNEL_CONSTS_VH

`define ADDR_DATA 3'h0
`define ADDR_IRQ_ENABLE 3'h1
`define ADDR_IRQ_STATUS 3'h2
`define ADDR_LINE_CONTROL 3'h3
`define ADDR_MODEM_CONTROL 3'h4
`define ADDR_LINE_STATUS 3'h5
`define ADDR_MODEM_STATUS 3'h6
`define ADDR_SCRATCH 3'h7

`define IRQ_ENABLE_RESET 4'h0
`define LINE_CONTROL_RESET 8'h00
`define MODEM_CONTROL_RESET 5'h00
`define DIVISOR_RESET 16'h0001
`define SCRATCH_RESET 8'hff

`define LC_DLAB 7
`define LC_BREAK 6
`define LC_FORCE 5
`define LC_EVEN 4
`define LC_PAR_EN 3
`define LC_STOP 2

`define MC_DTR 0
`define MC_RTS 1
`define MC_OUT1 2
`define MC_OUT2 3
`define MC_LOOP 4

`define IE_RX 0
`define IE_TX 1
`define IE_LINE 2
`define IE_MODEM 3

`define ISR_NONE 4'h1
`define ISR_LINE 4'h6
`define ISR_RX 4'h4
`define ISR_TX 4'h2
`define ISR_MODEM 4'h0

`define OVERSAMPLE 4'hf
`define START_SAMPLE 4'h7
`define HALF_BIT 4'h7

`endif

// *** tb/uart_channel_core_asserts.sv ***
/*
  Port checker for the serial channel core.
  Assumes one clock, an asynchronous active-high reset and divisor one.
*/
`timescale 1ns/100ps
`default_nettype none
module uart_channel_core_asserts (
  input wire logic clk_sys_in,
  input wire logic sys_rst_in,
  input wire logic cs_in,
  input wire logic [2:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  input wire logic [7:0] rdata_out,
  input wire logic tx_out,
  input wire logic dtr_n_out,
  input wire logic rts_n_out,
  input wire logic irq_out,
  input wire logic irq_oe_n_out
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (sys_rst_in);
  logic dlab_r;
  logic brk_r;
  logic [3:0] ier_r;
  wire wr_ok = cs_in & wr_in;
  wire rd_ok = cs_in & rd_in;
  // Shadow of the mode bits, so checks know which register is addressed
  always_ff @(posedge clk_sys_in or posedge sys_rst_in)
    if (sys_rst_in)
    begin
      dlab_r <= 1'b0;
      brk_r <= 1'b0;
      ier_r <= 4'h0;
    end
    else if (wr_ok && addr_in == 3'h3)
    begin
      dlab_r <= wdata_in[7];
      brk_r <= wdata_in[6];
    end
    else if (wr_ok && addr_in == 3'h1 && !dlab_r)
      ier_r <= wdata_in[3:0];
  a_status_layout: assert property (rd_ok && addr_in == 3'h2 |=>
    rdata_out[7:4] == 4'h0 && rdata_out[0] == !$past(irq_out)) else $error("status layout");
  a_status_codes: assert property (rd_ok && addr_in == 3'h2 |=>
    rdata_out[3:0] inside {4'h1, 4'h6, 4'h4, 4'h2, 4'h0} &&
    (rdata_out[3:0] != 4'h6 || ier_r[2]) && (rdata_out[3:0] != 4'h4 || ier_r[0]) &&
    (rdata_out[3:0] != 4'h2 || ier_r[1]) && (rdata_out[3:0] != 4'h0 || ier_r[3]))
    else $error("status code");
  a_enable_read: assert property (rd_ok && addr_in == 3'h1 && !dlab_r |=>
    rdata_out == {4'h0, $past(ier_r)}) else $error("enable readback");
  a_modem_upper: assert property (rd_ok && addr_in == 3'h4 |=>
    rdata_out[7:5] == 3'h0) else $error("modem control upper bits");
  a_modem_pins: assert property (wr_ok && addr_in == 3'h4 && !wdata_in[4] |=>
    {rts_n_out, dtr_n_out} == ~$past(wdata_in[1:0])) else $error("modem pins");
  a_irq_drive: assert property (wr_ok && addr_in == 3'h4 |=>
    irq_oe_n_out == !$past(wdata_in[3])) else $error("irq pin enable");
  a_break_low: assert property (wr_ok && addr_in == 3'h3 && wdata_in[6] |=>
    ##1 !tx_out [*4]) else $error("break not low");
  a_bit_width: assert property ($fell(tx_out) && !brk_r |->
    !tx_out [*8] ##7 !tx_out) else $error("low bit too short");
  a_irq_masked: assert property (ier_r == 4'h0 |-> !irq_out)
    else $error("irq with all enables off");
  c_irq_read: cover property (irq_out && rd_ok && addr_in == 3'h2);
  c_frame: cover property ($fell(tx_out) && !brk_r);
  c_break: cover property (brk_r && !tx_out);
endmodule
bind uart_channel_core uart_channel_core_asserts chk (.clk_sys_in, .sys_rst_in, .cs_in,
  .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out, .tx_out, .dtr_n_out, .rts_n_out,
  .irq_out, .irq_oe_n_out);
`default_nettype wire

// *** tb/serial_peer.sv ***
/*
  Remote serial device on the line side of the channel.
  Assumes divisor one, so one bit lasts sixteen system clocks.
*/
`timescale 1ns/100ps
`default_nettype none
module serial_peer (
  input wire logic clk_sys_in,
  input wire logic line_in,
  output logic line_out
);
  int cyc = 0;
  initial line_out = 1'b1;
  always @(posedge clk_sys_in)
    cyc <= cyc + 1;
  // Caller enters right after a rising edge
  task automatic put(input logic b, input int n);
    line_out <= b;
    repeat (n) @(posedge clk_sys_in);
  endtask
  task automatic send(input logic [7:0] d, input int nb, input int pe, input logic p);
    put(1'b0, 16);
    for (int i = 0; i < nb; i++)
      put(d[i], 16);
    if (pe)
      put(p, 16);
    put(1'b1, 16);
  endtask
  // Ends inside the stop bit, so a low last bit is not taken for a start
  task automatic recv(input int nb, input int pe, output logic [7:0] d, output logic p,
    output int t0);
    int w;
    w = 0;
    d = 8'h00;
    p = 1'b0;
    while (line_in && w < 4000)
    begin
      @(posedge clk_sys_in);
      w++;
    end
    t0 = cyc;
    repeat (8) @(posedge clk_sys_in);
    for (int i = 0; i < nb; i++)
    begin
      repeat (16) @(posedge clk_sys_in);
      d[i] = line_in;
    end
    if (pe)
    begin
      repeat (16) @(posedge clk_sys_in);
      p = line_in;
    end
    repeat (9) @(posedge clk_sys_in);
  endtask
endmodule
`default_nettype wire

// *** tb/uart_channel_core_test.sv ***
/*
  Self-checking bench for the serial channel core with a line peer.
  Assumes the divisor is at its reset value of one, apart from the divisor write check in t_regs.
*/
`timescale 1ns/100ps
`default_nettype none
module uart_channel_core_test;
  logic clk_sys_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic cs_in = 1'b0;
  logic [2:0] addr_in = 3'h0;
  logic [7:0] wdata_in = 8'h00;
  logic wr_in = 1'b0;
  logic rd_in = 1'b0;
  logic cts_n_in = 1'b1;
  wire [7:0] rdata_out;
  wire tx_out, rx_line, dtr_n_out, rts_n_out, irq_out, irq_oe_n_out;
  int failures = 0;
  int num_checks = 0;
  always #2 clk_sys_in = ~clk_sys_in;
  uart_channel_core dut (.clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in), .cs_in(cs_in),
    .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .rdata_out(rdata_out), .rx_in(rx_line), .tx_out(tx_out), .cts_n_in(cts_n_in),
    .dsr_n_in(1'b1), .ring_indicate_n_in(1'b1), .carrier_detect_n_in(1'b1),
    .dtr_n_out(dtr_n_out), .rts_n_out(rts_n_out), .irq_out(irq_out),
    .irq_oe_n_out(irq_oe_n_out));
  serial_peer peer (.clk_sys_in(clk_sys_in), .line_in(tx_out), .line_out(rx_line));
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  // Strobe is lowered with a spare edge, so the next call never doubles it
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    cs_in <= 1'b1;
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge clk_sys_in);
    wr_in <= 1'b0;
    @(posedge clk_sys_in);
  endtask
  task automatic rchk(input string what, input logic [2:0] a, input logic [7:0] m,
    input logic [7:0] exp);
    cs_in <= 1'b1;
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge clk_sys_in);
    rd_in <= 1'b0;
    @(posedge clk_sys_in);
    chk(what, exp, rdata_out & m);
  endtask
  task automatic t_reset();
    chk("pins", 16'h000f, {irq_out, dtr_n_out, rts_n_out, irq_oe_n_out, tx_out});
    rchk("enable", 3'h1, 8'hff, 8'h00);
    rchk("status", 3'h2, 8'hff, 8'h01);
    rchk("line ctl", 3'h3, 8'hff, 8'h00);
    rchk("modem ctl", 3'h4, 8'hff, 8'h00);
  endtask
  task automatic t_regs();
    wr(3'h1, 8'hff);
    rchk("enable", 3'h1, 8'hff, 8'h0f);
    wr(3'h3, 8'h80);
    rchk("divisor hi", 3'h1, 8'hff, 8'h00);
    rchk("divisor lo", 3'h0, 8'hff, 8'h01);
    wr(3'h0, 8'h5a);
    rchk("divisor wr", 3'h0, 8'hff, 8'h5a);
    wr(3'h0, 8'h01);
    wr(3'h3, 8'h00);
    rchk("no tx load", 3'h5, 8'h60, 8'h60);
    wr(3'h1, 8'h00);
    wr(3'h4, 8'hef);
    chk("pins on", 16'h0, {dtr_n_out, rts_n_out, irq_oe_n_out});
    rchk("modem ctl", 3'h4, 8'hff, 8'h0f);
    wr(3'h4, 8'h00);
    chk("pins off", 16'h7, {dtr_n_out, rts_n_out, irq_oe_n_out});
  endtask
  task automatic t_frames();
    logic [7:0] lcs [6] = '{8'h03, 8'h04, 8'h1a, 8'h09, 8'h2b, 8'h3f};
    logic [7:0] lc, d0, d1, g0, g1, mk;
    logic p0, p1, ep;
    int t0, t1, nb, pe, gap;
    for (int k = 0; k < 6; k++)
    begin
      lc = lcs[k];
      nb = 5 + int'(lc[1:0]);
      pe = int'(lc[3]);
      d0 = 8'h96 ^ 8'(k);
      d1 = 8'h4b ^ 8'(k << 4);
      mk = 8'hff >> (2'h3 - lc[1:0]);
      wr(3'h3, lc);
      fork
        begin
          wr(3'h0, d0);
          repeat (4) @(posedge clk_sys_in);
          wr(3'h0, d1);
          wr(3'h0, ~d1);
          rchk("tx busy", 3'h5, 8'h60, 8'h00);
        end
        begin
          peer.recv(nb, pe, g0, p0, t0);
          peer.recv(nb, pe, g1, p1, t1);
        end
      join
      ep = lc[5] ? ~lc[4] : (lc[4] ? ^(d1 & mk) : ~^(d1 & mk));
      gap = 16 * (1 + nb + pe) + (lc[2] ? (nb == 5 ? 24 : 32) : 16);
      chk("data0", d0 & mk, g0);
      chk("data1", d1 & mk, g1);
      chk("parity", pe ? ep : 1'b0, p1 & pe[0]);
      chk("frame gap", 1, t1 - t0 >= gap && t1 - t0 <= gap + 1);
      repeat (40) @(posedge clk_sys_in);
      rchk("tx empty", 3'h5, 8'h60, 8'h60);
    end
  endtask
  task automatic t_break();
    wr(3'h3, 8'h43);
    repeat (20) @(posedge clk_sys_in);
    chk("break line", 16'h0, tx_out);
    wr(3'h3, 8'h03);
    chk("line after break", 16'h1, tx_out);
  endtask
  task automatic t_rx_irq();
    wr(3'h1, 8'h01);
    peer.put(1'b0, 6);
    peer.put(1'b1, 200);
    rchk("false start", 3'h2, 8'hff, 8'h01);
    peer.send(8'h3c, 8, 0, 1'b0);
    repeat (4) @(posedge clk_sys_in);
    chk("irq rx", 16'h1, irq_out);
    wr(3'h1, 8'h03);
    rchk("status rx", 3'h2, 8'hff, 8'h04);
    rchk("rx data", 3'h0, 8'hff, 8'h3c);
    rchk("status tx", 3'h2, 8'hff, 8'h02);
    rchk("status idle", 3'h2, 8'hff, 8'h01);
    chk("irq idle", 16'h0, irq_out);
    wr(3'h3, 8'h1b);
    wr(3'h1, 8'h05);
    peer.send(8'h81, 8, 1, 1'b1);
    repeat (4) @(posedge clk_sys_in);
    rchk("status line", 3'h2, 8'hff, 8'h06);
    rchk("parity err", 3'h5, 8'h04, 8'h04);
    rchk("status rx2", 3'h2, 8'hff, 8'h04);
    rchk("rx data2", 3'h0, 8'hff, 8'h81);
    wr(3'h3, 8'h03);
  endtask
  task automatic t_modem();
    wr(3'h1, 8'h08);
    cts_n_in <= 1'b0;
    repeat (3) @(posedge clk_sys_in);
    chk("irq modem", 16'h1, irq_out);
    rchk("status modem", 3'h2, 8'hff, 8'h00);
    rchk("modem st", 3'h6, 8'h11, 8'h11);
    rchk("status clear", 3'h2, 8'hff, 8'h01);
    wr(3'h1, 8'h00);
    wr(3'h4, 8'h1e);
    rchk("loop modem", 3'h6, 8'hf0, 8'hd0);
    wr(3'h4, 8'h00);
  endtask
  task automatic wrap_up();
    $display("checks %0d, failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial
  begin
    repeat (12) @(posedge clk_sys_in);
    sys_rst_in <= 1'b0;
    @(posedge clk_sys_in);
    t_reset();
    t_regs();
    t_frames();
    t_break();
    t_rx_irq();
    t_modem();
    wrap_up();
  end
  // About nine times the expected run
  initial
  begin
    #100000;
    failures++;
    wrap_up();
  end
endmodule
`default_nettype wire
